/* File: core/dma_chan_cfg_pkg.sv */
// Constants for the per-channel trigger, event and interrupt configuration block
package dma_chan_cfg_pkg;
    // Structure
    localparam int NUM_CH    = 8;
    localparam int NUM_EV_CH = 4;   // Channels wired to the event system
    localparam int NUM_PREQ  = 46;  // Peripheral request lines, code 0 unused
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // Register byte addresses
    localparam logic [7:0] ADDR_CHANNEL_SELECT   = 8'h3f;
    localparam logic [7:0] ADDR_CONTROL_SECOND   = 8'h44;
    localparam logic [7:0] ADDR_IRQ_ENABLE_CLEAR = 8'h4c;
    localparam logic [7:0] ADDR_IRQ_ENABLE_SET   = 8'h4d;
    localparam logic [7:0] ADDR_IRQ_FLAG         = 8'h4e;

    // Field positions in channel_control_second
    localparam int ACTION_LSB    = 0;
    localparam int EV_IN_EN_BIT  = 3;
    localparam int EV_OUT_EN_BIT = 4;
    localparam int LEVEL_LSB     = 5;
    localparam int TSEL_LSB      = 8;
    localparam int TACT_LSB      = 22;

    // Interrupt bit positions
    localparam int IRQ_ERR_BIT     = 0;
    localparam int IRQ_DONE_BIT    = 1;
    localparam int IRQ_SUSPEND_BIT = 2;

    // Reset values
    localparam logic [3:0] RST_CHANNEL_SELECT = 4'h0;
    localparam logic [5:0] RST_TRIGGER_SELECT = 6'h00;
    localparam logic [2:0] RST_IRQ_ENABLE     = 3'h0;

    // Trigger selector code map
    localparam logic [5:0] TSEL_NONE         = 6'h00;
    localparam logic [5:0] TSEL_SERIAL_FIRST = 6'h01;
    localparam logic [5:0] TSEL_SERIAL_LAST  = 6'h0a;
    localparam logic [5:0] TSEL_CTIMER_FIRST = 6'h0b;
    localparam logic [5:0] TSEL_CTIMER_LAST  = 6'h15;
    localparam logic [5:0] TSEL_BTIMER_FIRST = 6'h16;
    localparam logic [5:0] TSEL_BTIMER_LAST  = 6'h24;
    localparam logic [5:0] TSEL_RESULT_READY = 6'h25;
    localparam logic [5:0] TSEL_DAC0_EMPTY   = 6'h26;
    localparam logic [5:0] TSEL_DAC1_EMPTY   = 6'h27;
    localparam logic [5:0] TSEL_RSVD_FIRST   = 6'h28;
    localparam logic [5:0] TSEL_RSVD_LAST    = 6'h2b;
    localparam logic [5:0] TSEL_CIPHER_WR    = 6'h2c;
    localparam logic [5:0] TSEL_CIPHER_RD    = 6'h2d;

    // Trigger granularity codes
    localparam logic [1:0] TACT_PER_BLOCK = 2'h0;
    localparam logic [1:0] TACT_RESERVED  = 2'h1;
    localparam logic [1:0] TACT_PER_BEAT  = 2'h2;
    localparam logic [1:0] TACT_PER_TRANS = 2'h3;

    // Event input action codes
    localparam logic [2:0] ACT_NO_ACTION    = 3'h0;
    localparam logic [2:0] ACT_TRIGGER      = 3'h1;
    localparam logic [2:0] ACT_COND_TRIGGER = 3'h2;
    localparam logic [2:0] ACT_COND_BLOCK   = 3'h3;
    localparam logic [2:0] ACT_SUSPEND      = 3'h4;
    localparam logic [2:0] ACT_RESUME       = 3'h5;
    localparam logic [2:0] ACT_SKIP_SUSPEND = 3'h6;
    localparam logic [2:0] ACT_RESERVED     = 3'h7;
endpackage : dma_chan_cfg_pkg

/* File: core/dma_chan_cfg.sv */
// Per-channel trigger, arbitration level, event and interrupt enable configuration
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Six-bit trigger selector, zero selects none
// - Codes 1-10: serial units rx/tx
// - Codes 11-21: control timer requests
// - Codes 22-36: basic timer requests
// - 0x25 result, 0x26/0x27 converter empty
// - 0x28-0x2B reserved, 0x2C/0x2D cipher
// - Two-bit level, higher level wins
// - Level writable while controller enabled
// - Output enable gates channel events
// - Event bits only on low channels
// - Input enable gates incoming events
// - Action acts only with input enable
// - Action codes one to three decoded, zero no action
// - Codes four to six decoded, seven reserved
// - Enable-clear write one disables interrupt
// - Set and clear share enable bits
// - Enable-clear acts on selected channel
// - Done flag needs enable or action
// - Trigger granularity field decoded
// - Enable-set write one enables interrupt
module dma_chan_cfg
    import dma_chan_cfg_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         ce_i,
    // Register port
    input  wire logic [ADDR_W-1:0]            addr_i,
    input  wire logic [DATA_W-1:0]            wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [DATA_W-1:0]            rdata_o,
    // Controller state and engine events
    input  wire logic                         ctrl_enable_i,
    input  wire logic [NUM_CH-1:0]            chan_pending_i,
    input  wire logic [NUM_CH-1:0]            block_done_i,
    input  wire logic [NUM_CH-1:0]            block_irq_act_i,
    input  wire logic [NUM_CH-1:0]            suspend_i,
    input  wire logic [NUM_CH-1:0]            error_i,
    input  wire logic [NUM_EV_CH-1:0]         ev_cond_i,
    // Far side: peripheral requests and event system
    input  wire logic [NUM_PREQ-1:0]          periph_req_i,
    input  wire logic [NUM_EV_CH-1:0]         ev_in_i,
    output logic      [NUM_EV_CH-1:0]         ev_out_o,
    // To the engine
    output logic      [NUM_CH-1:0]            trig_o,
    output logic      [NUM_CH-1:0][1:0]       gran_o,
    output logic      [NUM_EV_CH-1:0]         act_vld_o,
    output logic      [NUM_EV_CH-1:0][2:0]    act_code_o,
    output logic                              grant_vld_o,
    output logic      [2:0]                   grant_ch_o,
    output logic      [NUM_CH-1:0]            irq_o
);

    typedef struct packed {
        logic [3:0]                   ch_sel;
        logic [NUM_CH-1:0][5:0]       tsel;
        logic [NUM_CH-1:0][1:0]       tact;
        logic [NUM_CH-1:0][1:0]       gran;
        logic [NUM_CH-1:0][1:0]       level;
        logic [NUM_CH-1:0]            ev_out_en;
        logic [NUM_CH-1:0]            ev_in_en;
        logic [NUM_CH-1:0][2:0]       ev_action;
        logic [NUM_CH-1:0][2:0]       inten;
        logic [NUM_CH-1:0][2:0]       flag;
        logic [NUM_PREQ-1:0]          preq_s1;
        logic [NUM_PREQ-1:0]          preq_s2;
        logic [NUM_EV_CH-1:0]         ev_s1;
        logic [NUM_EV_CH-1:0]         ev_s2;
        logic [NUM_EV_CH-1:0]         ev_s3;
        logic [DATA_W-1:0]            rdata;
        logic [NUM_CH-1:0]            trig;
        logic [NUM_EV_CH-1:0]         evout;
        logic [NUM_EV_CH-1:0]         act_vld;
        logic [NUM_EV_CH-1:0][2:0]    act_code;
        logic                         grant_vld;
        logic [2:0]                   grant_ch;
        logic [NUM_CH-1:0]            irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Selected peripheral request, nothing for none or reserved codes
    function automatic logic trig_hit(input logic [5:0] code,
                                      input logic [NUM_PREQ-1:0] req);
        logic hit;
        hit = 1'b0;
        if (code == TSEL_NONE) begin
            hit = 1'b0;
        end else if (code >= TSEL_SERIAL_FIRST && code <= TSEL_SERIAL_LAST) begin
            hit = req[code];
        end else if (code >= TSEL_CTIMER_FIRST && code <= TSEL_CTIMER_LAST) begin
            hit = req[code];
        end else if (code >= TSEL_BTIMER_FIRST && code <= TSEL_BTIMER_LAST) begin
            hit = req[code];
        end else if (code >= TSEL_RESULT_READY && code <= TSEL_DAC1_EMPTY) begin
            hit = req[code];
        end else if (code == TSEL_CIPHER_WR || code == TSEL_CIPHER_RD) begin
            hit = req[code];
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction : trig_hit

    // Event action code to a valid action
    function automatic logic act_valid(input logic [2:0] code);
        logic v;
        // no action and reserved give nothing
        case (code)
            ACT_TRIGGER, ACT_COND_TRIGGER, ACT_COND_BLOCK,
            ACT_SUSPEND, ACT_RESUME, ACT_SKIP_SUSPEND: v = 1'b1;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : act_valid

    // Granularity code passed to the engine, reserved maps to per block
    function automatic logic [1:0] gran_map(input logic [1:0] code);
        logic [1:0] g;
        case (code)
            TACT_PER_BEAT:  g = TACT_PER_BEAT;
            TACT_PER_TRANS: g = TACT_PER_TRANS;
            default:        g = TACT_PER_BLOCK;
        endcase
        return g;
    endfunction : gran_map

    logic [2:0] sel;
    logic       sel_ok;

    assign sel    = s_r.ch_sel[2:0];
    assign sel_ok = (s_r.ch_sel < 4'(NUM_CH));

    // Next state
    always_comb begin
        logic [1:0] best;
        s_nxt = s_r;
        best  = 2'h0;

        // Two-flop capture of foreign inputs
        s_nxt.preq_s1 = periph_req_i;
        s_nxt.preq_s2 = s_r.preq_s1;
        s_nxt.ev_s1   = ev_in_i;
        s_nxt.ev_s2   = s_r.ev_s1;
        s_nxt.ev_s3   = s_r.ev_s2;

        if (wr_i && addr_i == ADDR_CHANNEL_SELECT) begin
            s_nxt.ch_sel = wdata_i[3:0];
        end

        // Control register writes to selected channel
        if (wr_i && addr_i == ADDR_CONTROL_SECOND && sel_ok) begin
            s_nxt.level[sel] = wdata_i[LEVEL_LSB +: 2];
            if (!ctrl_enable_i) begin
                s_nxt.tsel[sel] = wdata_i[TSEL_LSB +: 6];
                s_nxt.tact[sel] = wdata_i[TACT_LSB +: 2];
                // event bits only on low channels
                if (sel < 3'(NUM_EV_CH)) begin
                    s_nxt.ev_out_en[sel] = wdata_i[EV_OUT_EN_BIT];
                    s_nxt.ev_in_en[sel]  = wdata_i[EV_IN_EN_BIT];
                    s_nxt.ev_action[sel] = wdata_i[ACTION_LSB +: 3];
                end
            end
        end

        // one enable set for both ports
        if (sel_ok) begin
            if (wr_i && addr_i == ADDR_IRQ_ENABLE_CLEAR) begin
                s_nxt.inten[sel] = s_r.inten[sel] & ~wdata_i[2:0];
            end
            if (wr_i && addr_i == ADDR_IRQ_ENABLE_SET) begin
                s_nxt.inten[sel] = s_r.inten[sel] | wdata_i[2:0];
            end
            // Flag write-one clear
            if (wr_i && addr_i == ADDR_IRQ_FLAG) begin
                s_nxt.flag[sel] = s_r.flag[sel] & ~wdata_i[2:0];
            end
        end

        // Flag setting wins over a clear in the same cycle
        for (int c = 0; c < NUM_CH; c++) begin
            if (suspend_i[c]) begin
                s_nxt.flag[c][IRQ_SUSPEND_BIT] = 1'b1;
            end
            if (error_i[c]) begin
                s_nxt.flag[c][IRQ_ERR_BIT] = 1'b1;
            end
            // done flag needs enable or block action
            if (block_done_i[c] && (s_r.inten[c][IRQ_DONE_BIT] || block_irq_act_i[c])) begin
                s_nxt.flag[c][IRQ_DONE_BIT] = 1'b1;
            end
            s_nxt.irq[c]  = |(s_r.flag[c] & s_r.inten[c]);
            s_nxt.trig[c] = trig_hit(s_r.tsel[c], s_r.preq_s2);
            s_nxt.gran[c] = gran_map(s_nxt.tact[c]);
        end

        // Event inputs and outputs on event channels
        for (int e = 0; e < NUM_EV_CH; e++) begin
            s_nxt.evout[e]    = s_r.ev_out_en[e] & ev_cond_i[e];
            // incoming event gated by input enable
            s_nxt.act_vld[e]  = s_r.ev_in_en[e] & s_r.ev_s2[e] & ~s_r.ev_s3[e]
                                & act_valid(s_r.ev_action[e]);
            s_nxt.act_code[e] = s_r.ev_action[e];
        end

        // highest level pending wins, lowest number on a tie
        s_nxt.grant_vld = 1'b0;
        s_nxt.grant_ch  = 3'h0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (chan_pending_i[c] && (!s_nxt.grant_vld || s_r.level[c] > best)) begin
                s_nxt.grant_vld = 1'b1;
                s_nxt.grant_ch  = 3'(c);
                best            = s_r.level[c];
            end
        end

        // Read data for one cycle
        s_nxt.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_CHANNEL_SELECT: s_nxt.rdata = {28'h0000000, s_r.ch_sel};
                ADDR_CONTROL_SECOND: begin
                    if (sel_ok) begin
                        s_nxt.rdata = {8'h00, s_r.tact[sel], 8'h00, s_r.tsel[sel],
                                       1'b0, s_r.level[sel], s_r.ev_out_en[sel],
                                       s_r.ev_in_en[sel], s_r.ev_action[sel]};
                    end
                end
                ADDR_IRQ_ENABLE_CLEAR, ADDR_IRQ_ENABLE_SET: begin
                    if (sel_ok) begin
                        s_nxt.rdata = {29'h00000000, s_r.inten[sel]};
                    end
                end
                ADDR_IRQ_FLAG: begin
                    if (sel_ok) begin
                        s_nxt.rdata = {29'h00000000, s_r.flag[sel]};
                    end
                end
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r        <= '0;
            s_r.ch_sel <= RST_CHANNEL_SELECT;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata_o     = s_r.rdata;
    assign ev_out_o    = s_r.evout;
    assign trig_o      = s_r.trig;
    assign act_vld_o   = s_r.act_vld;
    assign act_code_o  = s_r.act_code;
    assign grant_vld_o = s_r.grant_vld;
    assign grant_ch_o  = s_r.grant_ch;
    assign irq_o       = s_r.irq;
    assign gran_o      = s_r.gran;

    // Assertions
    property p_trig_none;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && s_r.tsel[0] == TSEL_NONE) |=> !trig_o[0];
    endproperty
    a_trig_none: assert property (p_trig_none) else $error("trigger with none selected");

    property p_trig_map;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && s_r.tsel[0] >= TSEL_SERIAL_FIRST && s_r.tsel[0] <= TSEL_DAC1_EMPTY)
            |=> trig_o[0] == $past(s_r.preq_s2[s_r.tsel[0]]);
    endproperty
    a_trig_map: assert property (p_trig_map) else $error("trigger not from selected line");

    property p_trig_rsvd;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && (s_r.tsel[0] inside {[TSEL_RSVD_FIRST:TSEL_RSVD_LAST]} || s_r.tsel[0] > TSEL_CIPHER_RD))
            |=> !trig_o[0];
    endproperty
    a_trig_rsvd: assert property (p_trig_rsvd) else $error("reserved code triggered");

    property p_level_open;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_i && addr_i == ADDR_CONTROL_SECOND && s_r.ch_sel == 4'h0 && ctrl_enable_i)
            |=> s_r.level[0] == $past(wdata_i[LEVEL_LSB +: 2]) && $stable(s_r.tsel[0]);
    endproperty
    a_level_open: assert property (p_level_open) else $error("level or protection wrong");

    property p_ev_bits_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_i && addr_i == ADDR_CONTROL_SECOND && s_r.ch_sel >= 4'(NUM_EV_CH))
            |=> $stable(s_r.ev_in_en) && $stable(s_r.ev_out_en) && $stable(s_r.ev_action);
    endproperty
    a_ev_bits_low: assert property (p_ev_bits_low) else $error("event bits on upper channel");

    property p_evout_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !s_r.ev_out_en[0]) |=> !ev_out_o[0];
    endproperty
    a_evout_gate: assert property (p_evout_gate) else $error("event out while disabled");

    property p_evin_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !s_r.ev_in_en[0]) |=> !act_vld_o[0];
    endproperty
    a_evin_gate: assert property (p_evin_gate) else $error("event action while disabled");

    property p_act_rsvd;
        @(posedge clk_i) disable iff (!rst_n_i)
        act_vld_o[0] |-> act_code_o[0] != ACT_RESERVED && act_code_o[0] != ACT_NO_ACTION;
    endproperty
    a_act_rsvd: assert property (p_act_rsvd) else $error("null action issued");

    property p_en_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_i && addr_i == ADDR_IRQ_ENABLE_CLEAR && s_r.ch_sel == 4'h0 && wdata_i[1])
            |=> !s_r.inten[0][IRQ_DONE_BIT];
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable not cleared");

    property p_en_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_i && addr_i == ADDR_IRQ_ENABLE_SET && s_r.ch_sel == 4'h0 && wdata_i[2])
            |=> s_r.inten[0][IRQ_SUSPEND_BIT];
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable not set");

    property p_done_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !s_r.inten[0][IRQ_DONE_BIT] && !block_irq_act_i[0] && !s_r.flag[0][IRQ_DONE_BIT])
            |=> !s_r.flag[0][IRQ_DONE_BIT];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag set while off");

    property p_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && |(s_r.flag[0] & s_r.inten[0])) |=> irq_o[0];
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_grant;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && chan_pending_i[1] && chan_pending_i[0] && s_r.level[1] > s_r.level[0])
            |=> grant_vld_o && grant_ch_o != 3'h0;
    endproperty
    a_grant: assert property (p_grant) else $error("lower level granted");

endmodule : dma_chan_cfg

`default_nettype wire

/* File: tb/dma_far_side_model.sv */
// Behavioural peripheral request sources and event channels facing the block
`timescale 1ns/1ps
`default_nettype none
module dma_far_side_model
    import dma_chan_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // Bench commands
    input  wire logic [5:0]           req_code_i,
    input  wire logic                 req_on_i,
    input  wire logic [NUM_EV_CH-1:0] ev_fire_i,
    // Lines into the block
    output logic      [NUM_PREQ-1:0]  periph_req_o,
    output logic      [NUM_EV_CH-1:0] ev_in_o
);
    logic [NUM_EV_CH-1:0][1:0] hold_r;

    // One request line at a time, events stretched over three cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periph_req_o <= '0;
            hold_r       <= '0;
        end else begin
            periph_req_o <= req_on_i ? (NUM_PREQ'(1) << req_code_i) : '0;
            for (int i = 0; i < NUM_EV_CH; i++) begin
                hold_r[i] <= ev_fire_i[i] ? 2'h3 : hold_r[i] - {1'b0, |hold_r[i]};
            end
        end
    end

    // Long enough to cross the input synchronisers
    always_comb begin
        for (int i = 0; i < NUM_EV_CH; i++) begin
            ev_in_o[i] = |hold_r[i];
        end
    end
endmodule : dma_far_side_model
`default_nettype wire

/* File: tb/tb_dma_chan_cfg.sv */
// Self-checking bench for the channel trigger, event and interrupt configuration
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module tb_dma_chan_cfg
    import dma_chan_cfg_pkg::*;
();
    logic                      clk_i, rst_n_i, wr, rd, ctrl_en, req_on, gvld;
    logic [ADDR_W-1:0]         addr;
    logic [DATA_W-1:0]         wdata, rdata;
    logic [NUM_CH-1:0]         pend, bdone, bact, halt, err, trig, irq;
    logic [NUM_EV_CH-1:0]      ev_cond, ev_fire, ev_in, ev_out, act_vld;
    logic [NUM_EV_CH-1:0][2:0] act_code;
    logic [NUM_CH-1:0][1:0]    gran;
    logic [NUM_PREQ-1:0]       preq;
    logic [5:0]                req_code;
    logic [2:0]                gch;
    int                        fails, checks, cyc;

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    dma_chan_cfg i_dma_chan_cfg (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ctrl_enable_i(ctrl_en),
        .chan_pending_i(pend), .block_done_i(bdone), .block_irq_act_i(bact),
        .suspend_i(halt), .error_i(err), .ev_cond_i(ev_cond), .periph_req_i(preq),
        .ev_in_i(ev_in), .ev_out_o(ev_out), .trig_o(trig), .gran_o(gran),
        .act_vld_o(act_vld), .act_code_o(act_code), .grant_vld_o(gvld),
        .grant_ch_o(gch), .irq_o(irq));

    dma_far_side_model i_dma_far_side_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_code_i(req_code), .req_on_i(req_on),
        .ev_fire_i(ev_fire), .periph_req_o(preq), .ev_in_o(ev_in));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    function automatic logic exp_trig(input logic [5:0] c);
        return c != TSEL_NONE && c <= TSEL_CIPHER_RD && !(c >= TSEL_RSVD_FIRST && c <= TSEL_RSVD_LAST);
    endfunction : exp_trig

    // Highest level wins, lowest index on a tie
    function automatic logic [2:0] exp_grant(input logic [1:0] lv [NUM_CH],
                                             input logic [NUM_CH-1:0] pm);
        int best;
        best = -1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (pm[i] && (best < 0 || lv[i] > lv[best])) best = i;
        end
        return 3'(best);
    endfunction : exp_grant

    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    initial begin : main
        logic [31:0] d;
        logic [1:0]  ga;
        logic [1:0]  lv [NUM_CH];
        logic [2:0]  ch, en, clr, p, flg, got;
        logic [2:0]  en_m [NUM_CH];
        logic        b, seen;
        {rst_n_i, wr, rd, ctrl_en, req_on, addr, wdata, req_code} = '0;
        {pend, bdone, bact, halt, err, ev_cond, ev_fire} = '0;
        en_m = '{default: 3'h0};
        void'($urandom(32'h19efcc54));
        tick(20);
        rst_n_i <= 1'b1;
        rd_reg(ADDR_CONTROL_SECOND, d);
        `CHK(d, 32'h0)
        rd_reg(ADDR_IRQ_ENABLE_CLEAR, d);
        `CHK(d, 32'h0)
        rd_reg(8'h50, d);
        `CHK(d, 32'h0)
        for (int c = 0; c <= 45; c++) begin
            ch = 3'($urandom);
            ga = 2'($urandom);
            wr_reg(ADDR_CHANNEL_SELECT, 32'(ch));
            wr_reg(ADDR_CONTROL_SECOND, (32'(ga) << TACT_LSB) | (32'(c) << TSEL_LSB));
            req_code <= 6'(c);
            req_on   <= 1'b1;
            tick(5);
            `CHK(trig, exp_trig(6'(c)) ? (8'h1 << ch) : 8'h0)
            `CHK(gran[ch], (ga == TACT_RESERVED) ? TACT_PER_BLOCK : ga)
            req_on <= 1'b0;
            wr_reg(ADDR_CONTROL_SECOND, 32'h0);
            tick(4);
        end
        // levels rewritten while enabled, protected fields refused
        ctrl_en <= 1'b1;
        for (int it = 0; it < 16; it++) begin
            for (int i = 0; i < NUM_CH; i++) begin
                lv[i] = 2'($urandom);
                wr_reg(ADDR_CHANNEL_SELECT, 32'(i));
                wr_reg(ADDR_CONTROL_SECOND, (32'(lv[i]) << LEVEL_LSB) | 32'h3f1f);
            end
            rd_reg(ADDR_CONTROL_SECOND, d);
            `CHK(d, 32'(lv[7]) << LEVEL_LSB)
            pend <= 8'($urandom);
            tick(3);
            `CHK(gvld, |pend)
            if (pend != 0) `CHK(gch, exp_grant(lv, pend))
        end
        pend    <= 8'h0;
        ctrl_en <= 1'b0;
        // every action code, input enable off and on
        for (int i = 0; i < 16; i++) begin
            ch = 3'($urandom_range(NUM_EV_CH - 1));
            b  = 1'($urandom);
            wr_reg(ADDR_CHANNEL_SELECT, 32'(ch));
            wr_reg(ADDR_CONTROL_SECOND,
                   (32'(i / 8) << EV_IN_EN_BIT) | (32'(b) << EV_OUT_EN_BIT) | 32'(i % 8));
            @(posedge clk_i);
            ev_cond <= 4'h1 << ch;
            @(posedge clk_i);
            ev_cond <= 4'h0;
            #1;
            `CHK(ev_out, b ? (4'h1 << ch) : 4'h0)
            @(posedge clk_i);
            ev_fire <= 4'h1 << ch;
            @(posedge clk_i);
            ev_fire <= 4'h0;
            seen = 1'b0;
            got  = 3'h0;
            repeat (10) begin
                @(posedge clk_i);
                #1;
                if (act_vld[ch] === 1'b1) begin
                    seen = 1'b1;
                    got  = act_code[ch];
                end
            end
            `CHK(seen, i >= 8 && i % 8 != 0 && i % 8 != 7)
            if (seen) `CHK(got, 3'(i % 8))
        end
        // event bits absent on upper channels
        wr_reg(ADDR_CHANNEL_SELECT, 32'($urandom_range(NUM_CH - 1, NUM_EV_CH)));
        wr_reg(ADDR_CONTROL_SECOND, 32'h1f);
        rd_reg(ADDR_CONTROL_SECOND, d);
        `CHK(d[4:0], 5'h0)
        for (int i = 0; i < 12; i++) begin
            ch  = 3'($urandom);
            en  = 3'($urandom);
            clr = 3'($urandom);
            p   = 3'($urandom);
            b   = 1'($urandom);
            wr_reg(ADDR_CHANNEL_SELECT, 32'(ch));
            wr_reg(ADDR_IRQ_ENABLE_CLEAR, 32'h7);
            wr_reg(ADDR_IRQ_ENABLE_SET, 32'(en));
            wr_reg(ADDR_IRQ_ENABLE_CLEAR, 32'(clr));
            en       = en & ~clr;
            en_m[ch] = en;
            rd_reg(ADDR_IRQ_ENABLE_SET, d);
            `CHK(d, 32'(en))
            rd_reg(ADDR_IRQ_ENABLE_CLEAR, d);
            `CHK(d, 32'(en))
            wr_reg(ADDR_CHANNEL_SELECT, 32'(ch + 3'h1));
            rd_reg(ADDR_IRQ_ENABLE_SET, d);
            `CHK(d, 32'(en_m[ch + 3'h1]))
            wr_reg(ADDR_CHANNEL_SELECT, 32'h9);
            rd_reg(ADDR_IRQ_ENABLE_SET, d);
            `CHK(d, 32'h0)
            wr_reg(ADDR_CHANNEL_SELECT, 32'(ch));
            bact <= 8'(b) << ch;
            @(posedge clk_i);
            halt  <= 8'(p[2]) << ch;
            bdone <= 8'(p[1]) << ch;
            err   <= 8'(p[0]) << ch;
            @(posedge clk_i);
            {halt, bdone, err} <= '0;
            tick(3);
            flg = {p[2], p[1] & (en[1] | b), p[0]};
            `CHK(irq, |(flg & en) ? (8'h1 << ch) : 8'h0)
            rd_reg(ADDR_IRQ_FLAG, d);
            `CHK(d, 32'(flg))
            wr_reg(ADDR_IRQ_FLAG, 32'h7);
            bact <= 8'h0;
        end
        tick(4);
        // Reset in mid-run clears select and enables
        rst_n_i <= 1'b0;
        tick(2);
        `CHK(irq, 8'h0)
        rst_n_i <= 1'b1;
        rd_reg(ADDR_CHANNEL_SELECT, d);
        `CHK(d, 32'h0)
        rd_reg(ADDR_IRQ_ENABLE_SET, d);
        `CHK(d, 32'h0)
        end_sim();
    end
endmodule : tb_dma_chan_cfg
`default_nettype wire
